// [flash_seq_consts.vh]
// Contract
// - program counter steps by two per 24-bit program word
// - low-word table ops reach program bits 15..0 directly
// - only high-word table ops reach program bits 23..16
// - word-mode low read returns program bits 15..0 unchanged
// - byte-mode low read returns upper byte if select is 1, else lower
// - word-mode high read returns bits 23..16, upper data byte zero
// - byte-mode high read returns bits 23..16 or zero when select is 1
// - page register gives page; bit 7 selects configuration space
// - program one row; erase acts on an eight-row page
// - erase chosen by code 0010 with erase and write permit set
// - row program chosen by code 0001, erase clear, permit set
// - cycle proceeds only after keys 0x55 then 0xAA just before start
// - start bit launches cycle, stalls cpu, clears itself at end
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
`define CTL_START_BIT 15
`define CTL_PERMIT_BIT 14
`define CTL_ERASE_BIT 6
`define CTL_OP_MSB 3
`define CTL_RESET 16'h0000
`define OP_PAGE_ERASE 4'h2
`define OP_ROW_PROGRAM 4'h1
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define PAGE_CONFIG_BIT 7
`define ROW_WORDS 64
`define PAGE_ROWS 8
`define ERASE_CYCLES 32
`define PROGRAM_CYCLES 16
`endif

// [flash_word_mem.v]
`timescale 1ns/1ps
module flash_word_mem #(
   parameter AW = 10,
   parameter DW = 24
) (
   input wire i_sys_clk,
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [DW-1:0] i_wdata,
   input wire [AW-1:0] i_raddr,
   output reg [DW-1:0] o_rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule // flash_word_mem

// [program_flash_table_access_sequencer.v]
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module program_flash_table_access_sequencer #(
   parameter AW = 10,
   parameter ERASE_CYCLES = `ERASE_CYCLES,
   parameter PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_page_wr,
   input wire [7:0] i_page_data,
   input wire i_ctl_wr,
   input wire [15:0] i_ctl_data,
   input wire i_key_wr,
   input wire [7:0] i_key_data,
   input wire i_table_read_low_word,
   input wire i_table_read_high_word,
   input wire i_table_write_low_word,
   input wire i_table_write_high_word,
   input wire i_byte_mode,
   input wire [15:0] i_table_offset,
   input wire [15:0] i_table_wdata,
   output reg [15:0] o_rdata,
   output reg o_rvalid,
   output reg [7:0] o_program_page_select,
   output reg [15:0] o_flash_program_control,
   output reg o_cpu_stall,
   output reg o_config_access
);
   // ****************************************
   // state
   // ****************************************
   localparam K_IDLE = 3'b001;
   localparam K_GOT1 = 3'b010;
   localparam K_ARMED = 3'b100;
   localparam S_IDLE = 3'b001;
   localparam S_ERASE = 3'b010;
   localparam S_PROG = 3'b100;
   localparam RW = 6;
   localparam PW = 3;

   reg [2:0] key_q, key_d;
   reg [2:0] st_q, st_d;
   reg [15:0] cnt_q, cnt_d;
   reg [AW-1:0] walk_q, walk_d;
   reg [7:0] page_q;
   reg [15:0] ctl_q, ctl_d;
   reg [AW-1:0] base_q;
   reg rd_lo_q, rd_hi_q, bsel_q, bmode_q, rd_cfg_q;
   wire [7:0] cfg_q;
   wire [23:0] lane_rdata;

   // one program word per two byte addresses; bit 0 is the byte select
   wire [AW-1:0] word_addr = i_table_offset[AW:1];
   wire cfg_space = page_q[`PAGE_CONFIG_BIT];
   wire [RW-1:0] buf_idx = word_addr[RW-1:0];

   wire mem_we = (st_q != S_IDLE);
   wire [23:0] mem_wdata = (st_q == S_ERASE) ? 24'hFFFFFF : lane_rdata;
   wire [23:0] mem_rdata;
   wire any_rd = i_table_read_low_word | i_table_read_high_word;

   flash_word_mem #(.AW(AW), .DW(24)) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_we(mem_we),
      .i_waddr(walk_q),
      .i_wdata(mem_wdata),
      .i_raddr(word_addr),
      .o_rdata(mem_rdata)
   );

   // ****************************************
   // key sequence
   // ****************************************
   // any strobe other than the expected key breaks the unlock
   wire any_strobe = i_key_wr | i_ctl_wr | i_page_wr | any_rd | i_table_write_low_word |
                     i_table_write_high_word;
   always @* begin
      key_d = key_q;
      case (key_q)
         K_IDLE: begin
            key_d = K_IDLE;
         end
         K_GOT1: begin
            if (i_key_wr && i_key_data == `KEY_SECOND) begin
               key_d = K_ARMED;
            end else if (any_strobe) begin
               key_d = K_IDLE;
            end
         end
         K_ARMED: begin
            // the unlock only holds for the write directly after the keys
            if (any_strobe) begin
               key_d = K_IDLE;
            end
         end
         default: begin
            key_d = K_IDLE;
         end
      endcase
      // a first key restarts the sequence from any state, so a repeated first key is harmless
      if (i_key_wr && i_key_data == `KEY_FIRST) begin
         key_d = K_GOT1;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always @* begin
      st_d = st_q;
      cnt_d = cnt_q;
      walk_d = walk_q;
      ctl_d = ctl_q;
      case (st_q)
         S_IDLE: begin
            if (i_ctl_wr) begin
               // start bit is never stored from the bus; only a launch sets it
               ctl_d = {1'b0, i_ctl_data[14:0]};
               if (i_ctl_data[`CTL_START_BIT] && key_q == K_ARMED &&
                   i_ctl_data[`CTL_PERMIT_BIT]) begin
                  if (i_ctl_data[`CTL_OP_MSB:0] == `OP_PAGE_ERASE &&
                      i_ctl_data[`CTL_ERASE_BIT]) begin
                     st_d = S_ERASE;
                     ctl_d[`CTL_START_BIT] = 1'b1;
                     walk_d = {base_q[AW-1:RW+PW], {(RW+PW){1'b0}}};
                     cnt_d = ERASE_CYCLES[15:0];
                  end else if (i_ctl_data[`CTL_OP_MSB:0] == `OP_ROW_PROGRAM &&
                               !i_ctl_data[`CTL_ERASE_BIT]) begin
                     st_d = S_PROG;
                     ctl_d[`CTL_START_BIT] = 1'b1;
                     walk_d = {base_q[AW-1:RW], {RW{1'b0}}};
                     cnt_d = PROGRAM_CYCLES[15:0];
                  end
               end
            end
         end
         S_ERASE: begin
            walk_d = walk_q + 1'b1;
            if (walk_q[RW+PW-1:0] == {(RW+PW){1'b1}}) begin
               walk_d = walk_q;
               if (cnt_q <= 16'h0001) begin
                  st_d = S_IDLE;
                  ctl_d[`CTL_START_BIT] = 1'b0;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
         end
         S_PROG: begin
            walk_d = walk_q + 1'b1;
            if (walk_q[RW-1:0] == {RW{1'b1}}) begin
               walk_d = walk_q;
               if (cnt_q <= 16'h0001) begin
                  st_d = S_IDLE;
                  ctl_d[`CTL_START_BIT] = 1'b0;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
         end
         default: begin
            st_d = S_IDLE;
            ctl_d[`CTL_START_BIT] = 1'b0;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         key_q <= K_IDLE;
         st_q <= S_IDLE;
         cnt_q <= 16'h0000;
         walk_q <= {AW{1'b0}};
         ctl_q <= `CTL_RESET;
         page_q <= 8'h00;
         base_q <= {AW{1'b0}};
      end else begin
         key_q <= key_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         // hold the walk address idle so a stray write port use is harmless
         walk_q <= walk_d;
         ctl_q <= ctl_d;
         if (i_page_wr && st_q == S_IDLE) begin
            page_q <= i_page_data;
         end
         if ((i_table_write_low_word || i_table_write_high_word) && !cfg_space) begin
            base_q <= word_addr;
         end
      end
   end

   // ****************************************
   // table writes into row latches
   // ****************************************
   // latches and config bytes have no reset; software loads them before use
   // one memory per byte lane lets a byte-mode write touch a single lane
   wire [2:0] lane_we;
   wire [23:0] lane_wdata;
   wire cfg_we;
   genvar g;

   assign lane_we[0] = i_table_write_low_word && !cfg_space &&
                       !(i_byte_mode && i_table_offset[0]);
   assign lane_we[1] = i_table_write_low_word && !cfg_space &&
                       !(i_byte_mode && !i_table_offset[0]);
   assign lane_we[2] = i_table_write_high_word && !cfg_space &&
                       !(i_byte_mode && i_table_offset[0]);
   assign lane_wdata = {i_table_wdata[7:0],
                        i_byte_mode ? i_table_wdata[7:0] : i_table_wdata[15:8],
                        i_table_wdata[7:0]};
   assign cfg_we = i_table_write_low_word && cfg_space && !(i_byte_mode && i_table_offset[0]);

   // lanes are read at the next walk address so their registered data
   // lines up with the flash write of the following cycle
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_lane
         flash_word_mem #(.AW(RW), .DW(8)) u_lane (
            .i_sys_clk(i_sys_clk),
            .i_we(lane_we[g]),
            .i_waddr(buf_idx),
            .i_wdata(lane_wdata[8*g+7:8*g]),
            .i_raddr(walk_d[RW-1:0]),
            .o_rdata(lane_rdata[8*g+7:8*g])
         );
      end
   endgenerate

   flash_word_mem #(.AW(8), .DW(8)) u_cfg (
      .i_sys_clk(i_sys_clk),
      .i_we(cfg_we),
      .i_waddr(i_table_offset[8:1]),
      .i_wdata(i_table_wdata[7:0]),
      .i_raddr(i_table_offset[8:1]),
      .o_rdata(cfg_q)
   );

   // ****************************************
   // table reads
   // ****************************************
   always @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         rd_lo_q <= 1'b0;
         rd_hi_q <= 1'b0;
         bsel_q <= 1'b0;
         bmode_q <= 1'b0;
         rd_cfg_q <= 1'b0;
      end else begin
         rd_lo_q <= i_table_read_low_word;
         rd_hi_q <= i_table_read_high_word & ~i_table_read_low_word;
         bsel_q <= i_table_offset[0];
         bmode_q <= i_byte_mode;
         rd_cfg_q <= cfg_space;
      end
   end

   reg [15:0] rd_d;
   always @* begin
      rd_d = 16'h0000;
      if (rd_cfg_q) begin
         rd_d = {8'h00, (rd_lo_q && bmode_q && bsel_q) ? 8'h00 : cfg_q};
         if (rd_hi_q) begin
            rd_d = 16'h0000;
         end
      end else if (rd_lo_q) begin
         if (!bmode_q) begin
            rd_d = mem_rdata[15:0];
         end else if (bsel_q) begin
            rd_d = {8'h00, mem_rdata[15:8]};
         end else begin
            rd_d = {8'h00, mem_rdata[7:0]};
         end
      end else if (rd_hi_q) begin
         if (bmode_q && bsel_q) begin
            rd_d = 16'h0000;
         end else begin
            rd_d = {8'h00, mem_rdata[23:16]};
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         o_program_page_select <= 8'h00;
         o_flash_program_control <= `CTL_RESET;
         o_cpu_stall <= 1'b0;
         o_config_access <= 1'b0;
      end else begin
         o_rdata <= rd_d;
         o_rvalid <= rd_lo_q | rd_hi_q;
         o_program_page_select <= page_q;
         o_flash_program_control <= ctl_d;
         o_cpu_stall <= (st_d != S_IDLE);
         o_config_access <= cfg_space;
      end
   end
endmodule // program_flash_table_access_sequencer

// [flash_seq_monitor.sv]
`timescale 1ns/1ps
module flash_seq_monitor #(parameter ERASE_CYCLES = 32) (
   input logic i_sys_clk,
   input logic i_resetn,
   input logic i_page_wr,
   input logic [7:0] i_page_data,
   input logic i_ctl_wr,
   input logic [15:0] i_ctl_data,
   input logic i_key_wr,
   input logic [7:0] i_key_data,
   input logic i_table_read_low_word,
   input logic i_table_read_high_word,
   input logic i_table_write_low_word,
   input logic i_table_write_high_word,
   input logic i_byte_mode,
   input logic [15:0] i_table_offset,
   input logic [15:0] i_table_wdata,
   input logic [15:0] o_rdata,
   input logic o_rvalid,
   input logic [7:0] o_program_page_select,
   input logic [15:0] o_flash_program_control,
   input logic o_cpu_stall,
   input logic o_config_access
);
   localparam int LIM = 520 + ERASE_CYCLES;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   wire rd = i_table_read_low_word | i_table_read_high_word;
   sequence keys_s;
      i_key_wr && i_key_data == 8'h55 ##1 i_key_wr && i_key_data == 8'hAA;
   endsequence
   sequence start_s;
      i_ctl_wr && i_ctl_data[15:14] == 2'b11 && !o_cpu_stall &&
      ((i_ctl_data[6] && i_ctl_data[3:0] == 4'h2) ||
       (!i_ctl_data[6] && i_ctl_data[3:0] == 4'h1));
   endsequence
   a_read_answer_time: assert property (rd |-> ##2 o_rvalid) else $error("late");
   a_read_valid_cause: assert property (o_rvalid |-> $past(rd, 2)) else $error("stray");
   a_high_phantom_zero: assert property (o_rvalid && $past(i_table_read_high_word &&
      !i_table_read_low_word, 2) |-> o_rdata[15:8] == 8'h00) else $error("phantom");
   a_unlock_then_start: assert property (keys_s ##1 start_s |=>
      o_cpu_stall && o_flash_program_control[15]) else $error("no start");
   a_stall_tracks_bit: assert property (o_cpu_stall == o_flash_program_control[15])
      else $error("stall bit");
   a_stall_ends_bound: assert property (o_cpu_stall |-> ##[1:LIM] !o_cpu_stall)
      else $error("hung");
   a_page_copy_held: assert property (i_page_wr && !o_cpu_stall ##1 !i_page_wr |=>
      o_program_page_select == $past(i_page_data, 2)) else $error("page");
   a_config_space_flag: assert property (o_config_access == o_program_page_select[7])
      else $error("config");
   a_permit_refuse_start: assert property (i_ctl_wr && !i_ctl_data[14] && !o_cpu_stall
      |=> !o_cpu_stall) else $error("permit");
endmodule // flash_seq_monitor
bind program_flash_table_access_sequencer flash_seq_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) mon (.*);

// [cpu_model.sv]
`timescale 1ns/1ps
module cpu_model (
   input logic i_sys_clk,
   output logic o_key_wr,
   output logic [7:0] o_key_data,
   output logic o_ctl_wr,
   output logic [15:0] o_ctl_data
);
   initial begin
      o_key_wr = 1'b0;
      o_key_data = 8'h00;
      o_ctl_wr = 1'b0;
      o_ctl_data = 16'h0000;
   end
   task automatic launch(input logic [15:0] ctl, input logic [7:0] k2, input bit keys);
      if (keys) begin
         @(negedge i_sys_clk);
         o_key_wr = 1'b1;
         o_key_data = 8'h55;
         @(negedge i_sys_clk);
         o_key_data = k2;
      end
      @(negedge i_sys_clk);
      o_key_wr = 1'b0;
      o_ctl_wr = 1'b1;
      o_ctl_data = ctl;
      @(negedge i_sys_clk);
      o_ctl_wr = 1'b0;
      repeat (2) @(negedge i_sys_clk);
   endtask
endmodule // cpu_model

// [program_flash_table_access_sequencer_bench.sv]
`timescale 1ns/1ps
module program_flash_table_access_sequencer_bench;
   logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_page_wr = 1'b0, i_byte_mode = 1'b0;
   logic i_table_read_low_word = 1'b0, i_table_read_high_word = 1'b0;
   logic i_table_write_low_word = 1'b0, i_table_write_high_word = 1'b0;
   logic [7:0] i_page_data = 8'h00, i_key_data, o_program_page_select;
   logic [15:0] i_table_offset = 16'h0000, i_table_wdata = 16'h0000;
   logic [15:0] i_ctl_data, o_rdata, o_flash_program_control;
   logic i_key_wr, i_ctl_wr, o_rvalid, o_cpu_stall, o_config_access;
   logic [31:0] seed = 32'd38, t;
   logic [23:0] m [int];
   int err_total = 0, cmp_count = 0, i, j;
   program_flash_table_access_sequencer #(.ERASE_CYCLES(4), .PROGRAM_CYCLES(3)) DUT (.*);
   cpu_model cpu (.i_sys_clk(i_sys_clk), .o_key_wr(i_key_wr), .o_key_data(i_key_data),
      .o_ctl_wr(i_ctl_wr), .o_ctl_data(i_ctl_data));
   always #25 i_sys_clk = ~i_sys_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tw(input bit hi, input logic [15:0] off, input logic [15:0] d);
      @(negedge i_sys_clk);
      i_table_offset = off;
      i_table_wdata = d;
      i_table_write_low_word = !hi;
      i_table_write_high_word = hi;
      @(negedge i_sys_clk);
      i_table_write_low_word = 1'b0;
      i_table_write_high_word = 1'b0;
   endtask
   task automatic pg(input logic [7:0] d);
      @(negedge i_sys_clk);
      i_page_wr = 1'b1;
      i_page_data = d;
      @(negedge i_sys_clk);
      i_page_wr = 1'b0;
      // the page outputs follow the page register one edge later
      @(negedge i_sys_clk);
      chk("page", {o_config_access, o_program_page_select}, {d[7], d});
   endtask
   task automatic tr(input bit hi, input bit bm, input logic [15:0] off);
      logic [23:0] w;
      logic [15:0] e;
      w = m[off >> 1];
      e = hi ? {8'h00, w[23:16]} : w[15:0];
      if (bm) e = hi ? (off[0] ? 16'h0000 : e) : {8'h00, off[0] ? w[15:8] : w[7:0]};
      trx(hi, bm, off, e);
   endtask
   task automatic trx(input bit hi, input bit bm, input logic [15:0] off, input logic [15:0] e);
      @(negedge i_sys_clk);
      i_table_offset = off;
      i_byte_mode = bm;
      i_table_read_low_word = !hi;
      i_table_read_high_word = hi;
      @(negedge i_sys_clk);
      i_table_read_low_word = 1'b0;
      i_table_read_high_word = 1'b0;
      @(negedge i_sys_clk);
      chk("rvalid", o_rvalid, 1'b1);
      chk("rdata", o_rdata, e);
   endtask
   task automatic run(input logic [15:0] ctl, input logic [7:0] k2, input bit keys, input bit ok);
      int k;
      cpu.launch(ctl, k2, keys);
      chk("stall", o_cpu_stall, ok);
      for (k = 0; k < 2000 && o_cpu_stall; k++) @(negedge i_sys_clk);
      chk("ctl", o_flash_program_control, {1'b0, ctl[14:0]});
   endtask
   initial begin
      repeat (4) @(negedge i_sys_clk);
      i_resetn = 1'b1;
      chk("reset", {o_flash_program_control, o_cpu_stall, o_rvalid}, 18'h0);
      for (i = 0; i < 2; i++) pg(i ? 8'h00 : 8'h80);
      tw(1'b0, 16'h0000, 16'h0000);
      run(16'hC042, 8'hAA, 1'b1, 1'b1);
      for (i = 0; i < 512; i++) m[i] = 24'hFFFFFF;
      for (i = 0; i < 64; i++) begin
         t = rnd();
         tw(1'b0, 16'(2 * i), t[15:0]);
         tw(1'b1, 16'(2 * i), {8'h00, t[23:16]});
         m[i] = t[23:0];
      end
      run(16'hC001, 8'hAA, 1'b1, 1'b1);
      run(16'hC001, 8'hAA, 1'b0, 1'b0);
      run(16'hC001, 8'h12, 1'b1, 1'b0);
      run(16'h8001, 8'hAA, 1'b1, 1'b0);
      for (i = 0; i < 66; i++) begin
         for (j = 0; j < 4; j++) tr(j[1], j[0], 16'(2 * i + (rnd() & 1)));
      end
      pg(8'h80);
      for (i = 0; i < 4; i++) begin
         t = rnd();
         tw(1'b0, 16'(2 * i), {8'h00, t[7:0]});
         for (j = 0; j < 4; j++) begin
            trx(j[1], j[0], 16'(2 * i) | t[8],
               (!j[1] && !(j[0] && t[8])) ? {8'h00, t[7:0]} : 16'h0000);
         end
      end
      close_out();
   end
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      err_total++;
      close_out();
   end
endmodule // program_flash_table_access_sequencer_bench
